/* File: pkg/light_level_pkg.sv */
// Purpose: Shared constants and types of the ambient level backlight selector.
// Assumes: APB register file with one aligned word per register.
// Notes: Register indices are word indices; byte address is four times the index.
package light_level_pkg;

	// Widths
	localparam int unsigned CODE_W = 7;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned IRQ_W = 3;

	// Register word indices
	localparam logic [5:0] IDX_DAY_PEAK = 6'h05;
	localparam logic [5:0] IDX_DAY_DIM = 6'h06;
	localparam logic [5:0] IDX_OFFICE_PEAK = 6'h07;
	localparam logic [5:0] IDX_OFFICE_DIM = 6'h08;
	localparam logic [5:0] IDX_NIGHT_PEAK = 6'h09;
	localparam logic [5:0] IDX_NIGHT_DIM = 6'h0A;
	localparam logic [5:0] IDX_PRESENT = 6'h0B;
	localparam logic [5:0] IDX_CFG = 6'h0C;
	localparam logic [5:0] IDX_OFFICE_TRIP = 6'h0D;
	localparam logic [5:0] IDX_OFFICE_HYS = 6'h0E;
	localparam logic [5:0] IDX_NIGHT_TRIP = 6'h0F;
	localparam logic [5:0] IDX_NIGHT_HYS = 6'h10;
	localparam logic [5:0] IDX_CTRL = 6'h20;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h21;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h22;

	// Comparator configuration fields
	localparam int unsigned CFG_SETTLE_LSB = 5;
	localparam int unsigned CFG_FORCE_BIT = 4;
	localparam int unsigned CFG_NIGHT_FLAG_BIT = 3;
	localparam int unsigned CFG_OFFICE_FLAG_BIT = 2;
	localparam int unsigned CFG_NIGHT_ON_BIT = 1;
	localparam int unsigned CFG_OFFICE_ON_BIT = 0;

	// Control and interrupt fields
	localparam int unsigned CTRL_AUTO_BIT = 0;
	localparam int unsigned IRQ_NIGHT_BIT = 0;
	localparam int unsigned IRQ_OFFICE_BIT = 1;
	localparam int unsigned IRQ_FORCE_BIT = 2;

	// Values after reset
	localparam logic [6:0] RST_CODE = 7'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_SETTLE = 3'h0;
	localparam logic [2:0] RST_IRQ = 3'h0;

	// Filter base period and its cycle count
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned FILTER_BASE_US = 80000;
	localparam int unsigned FILTER_BASE_CYC = FILTER_BASE_US * CLK_MHZ;

	// Selected ambient level
	typedef enum logic [1:0] {
		LVL_DAY,
		LVL_OFFICE,
		LVL_NIGHT
	} level_t;

endpackage

/* File: rtl/level_comparator.sv */
// Purpose: One light level comparator with hysteresis and settle filter.
// Assumes: Light code arrives on pclk from the converter.
// Notes: Flag clears while disabled; forced conversion bypasses the filter.
`timescale 1ns/1ps
module level_comparator
	import light_level_pkg::*;
#(
	parameter int unsigned CW = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic enable,
	input wire logic force_conv,
	input wire logic [7:0] light,
	input wire logic [7:0] trip,
	input wire logic [7:0] hys,
	input wire logic [CW-1:0] period,
	output logic flag,
	output logic rise
);

	logic flag_r;
	logic rise_r;
	logic [CW-1:0] cnt_r;
	logic flag_nxt;
	logic [CW-1:0] cnt_nxt;

	// Trip decision with hysteresis band
	wire [8:0] clear_level = {1'b0, trip} + {1'b0, hys};
	wire want = flag_r ? !({1'b0, light} > clear_level) : (light < trip);
	wire differs = (want != flag_r);
	wire cnt_done = differs && (cnt_r >= period - CW'(1));

	assign flag_nxt = !enable ? 1'b0 : (force_conv || cnt_done) ? want : flag_r;
	assign cnt_nxt = (!enable || force_conv || !differs || cnt_done) ? '0 : cnt_r + CW'(1);

	// Flag, counter and rise event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
			cnt_r <= '0;
			rise_r <= 1'b0;
		end else if (ce) begin
			flag_r <= flag_nxt;
			cnt_r <= cnt_nxt;
			rise_r <= flag_nxt & ~flag_r;
		end
	end

	assign flag = flag_r;
	assign rise = rise_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_filter_hold: assert property (flag_r != $past(flag_r) |-> $past(!ce || !enable || force_conv || cnt_done))
		else $error("flag moved before settle period");
	a_trip_set: assert property (ce && enable && !flag_r && light < trip && cnt_done |=> flag_r)
		else $error("flag not set below trip");
	a_hys_clear: assert property (ce && enable && flag_r && {1'b0, light} > clear_level && cnt_done |=> !flag_r)
		else $error("flag not cleared above trip plus hysteresis");
	a_disable_clear: assert property (ce && !enable |=> !flag_r)
		else $error("disabled comparator kept flag");

endmodule // level_comparator

/* File: rtl/ambient_level_backlight_select.sv */
// Purpose: Ambient level comparators and backlight current code selection.
// Assumes: APB slave on pclk; light codes come from a converter on pclk.
// Notes: Zero wait states while ce is high; read data loads on the first ce-high edge.
// Functional notes
// - Office level uses peak and dim codes.
// - Night level uses peak and dim codes.
// - Present backlight code readable, writes ignored.
// - Filter period doubles per code step.
// - Forced read runs once, then clears.
// - Night flag set on drop to night.
// - Office flag set on drop to office.
// - Config bit one enables night comparator.
// - Config bit zero enables office comparator.
// - Office flag sets below office threshold.
// - Office flag clears above threshold plus hysteresis.
// - Night flag sets below night threshold.
// - Night flag clears above threshold plus hysteresis.
// - Daylight level uses its own codes.
`timescale 1ns/1ps
module ambient_level_backlight_select
	import light_level_pkg::*;
#(
	parameter int unsigned FILTER_BASE_CYCLES = FILTER_BASE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] office_light_code,
	input wire logic [7:0] night_light_code,
	input wire logic dim_active,
	output logic [6:0] backlight_code,
	output level_t selected_light_level,
	output logic irq
);

	// Current code registers
	logic [CODE_W-1:0] day_peak_r;
	logic [CODE_W-1:0] day_dim_r;
	logic [CODE_W-1:0] office_peak_r;
	logic [CODE_W-1:0] office_dim_r;
	logic [CODE_W-1:0] night_peak_r;
	logic [CODE_W-1:0] night_dim_r;

	// Comparator configuration
	logic [2:0] settle_sel_r;
	logic force_r;
	logic night_on_r;
	logic office_on_r;
	logic [7:0] office_trip_r;
	logic [7:0] office_hys_r;
	logic [7:0] night_trip_r;
	logic [7:0] night_hys_r;

	// Control, interrupts and outputs
	logic auto_r, rd_loaded_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [IRQ_W-1:0] irq_stat_nxt;
	logic [CODE_W-1:0] backlight_code_r;
	logic [CODE_W-1:0] code_nxt;
	level_t level_r;
	level_t level_nxt;
	logic [31:0] prdata_r;
	logic [7:0] rdata;

	// Comparator results
	logic office_flag;
	logic night_flag;
	logic office_rise;
	logic night_rise;

	// Address decode
	wire [5:0] reg_idx = paddr[7:2];
	wire hit_day_peak = (reg_idx == IDX_DAY_PEAK);
	wire hit_day_dim = (reg_idx == IDX_DAY_DIM);
	wire hit_office_peak = (reg_idx == IDX_OFFICE_PEAK);
	wire hit_office_dim = (reg_idx == IDX_OFFICE_DIM);
	wire hit_night_peak = (reg_idx == IDX_NIGHT_PEAK);
	wire hit_night_dim = (reg_idx == IDX_NIGHT_DIM);
	wire hit_present = (reg_idx == IDX_PRESENT);
	wire hit_cfg = (reg_idx == IDX_CFG);
	wire hit_office_trip = (reg_idx == IDX_OFFICE_TRIP);
	wire hit_office_hys = (reg_idx == IDX_OFFICE_HYS);
	wire hit_night_trip = (reg_idx == IDX_NIGHT_TRIP);
	wire hit_night_hys = (reg_idx == IDX_NIGHT_HYS);
	wire hit_ctrl = (reg_idx == IDX_CTRL);
	wire hit_irq_stat = (reg_idx == IDX_IRQ_STAT);
	wire hit_irq_mask = (reg_idx == IDX_IRQ_MASK);
	wire addr_hit = hit_day_peak | hit_day_dim | hit_office_peak | hit_office_dim
		| hit_night_peak | hit_night_dim | hit_present | hit_cfg
		| hit_office_trip | hit_office_hys | hit_night_trip | hit_night_hys
		| hit_ctrl | hit_irq_stat | hit_irq_mask;

	// Bus phases; an access completes only once read data is loaded
	wire setup_phase = ce && psel && !penable;
	wire access_phase = ce && psel && penable && rd_loaded_r;
	wire load_rd = ce && psel && (!penable || !rd_loaded_r);
	wire wr_fire = access_phase && pwrite && pstrb[0] && addr_hit;
	wire [7:0] wbyte = pwdata[7:0];

	// Per register write strobes
	wire wr_day_peak = wr_fire && hit_day_peak;
	wire wr_day_dim = wr_fire && hit_day_dim;
	wire wr_office_peak = wr_fire && hit_office_peak;
	wire wr_office_dim = wr_fire && hit_office_dim;
	wire wr_night_peak = wr_fire && hit_night_peak;
	wire wr_night_dim = wr_fire && hit_night_dim;
	wire wr_cfg = wr_fire && hit_cfg;
	wire wr_office_trip = wr_fire && hit_office_trip;
	wire wr_office_hys = wr_fire && hit_office_hys;
	wire wr_night_trip = wr_fire && hit_night_trip;
	wire wr_night_hys = wr_fire && hit_night_hys;
	wire wr_ctrl = wr_fire && hit_ctrl;
	wire wr_irq_stat = wr_fire && hit_irq_stat;
	wire wr_irq_mask = wr_fire && hit_irq_mask;

	// Daylight codes
	// daylight code storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			day_peak_r <= RST_CODE;
			day_dim_r <= RST_CODE;
		end else begin
			if (wr_day_peak) day_peak_r <= wbyte[CODE_W-1:0];
			if (wr_day_dim) day_dim_r <= wbyte[CODE_W-1:0];
		end
	end

	// Office codes
	// office code storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			office_peak_r <= RST_CODE;
			office_dim_r <= RST_CODE;
		end else begin
			if (wr_office_peak) office_peak_r <= wbyte[CODE_W-1:0];
			if (wr_office_dim) office_dim_r <= wbyte[CODE_W-1:0];
		end
	end

	// Night codes
	// night code storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			night_peak_r <= RST_CODE;
			night_dim_r <= RST_CODE;
		end else begin
			if (wr_night_peak) night_peak_r <= wbyte[CODE_W-1:0];
			if (wr_night_dim) night_dim_r <= wbyte[CODE_W-1:0];
		end
	end

	// Comparator configuration; flag bits are not writable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_sel_r <= RST_SETTLE;
			night_on_r <= 1'b0;
			office_on_r <= 1'b0;
		end else if (wr_cfg) begin
			settle_sel_r <= wbyte[CFG_SETTLE_LSB+2:CFG_SETTLE_LSB];
			night_on_r <= wbyte[CFG_NIGHT_ON_BIT];
			office_on_r <= wbyte[CFG_OFFICE_ON_BIT];
		end
	end

	// forced read lasts one conversion cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_r <= 1'b0;
		end else if (ce) begin
			force_r <= wr_cfg && wbyte[CFG_FORCE_BIT];
		end
	end

	// Thresholds and hysteresis
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			office_trip_r <= RST_BYTE;
			office_hys_r <= RST_BYTE;
			night_trip_r <= RST_BYTE;
			night_hys_r <= RST_BYTE;
		end else begin
			if (wr_office_trip) office_trip_r <= wbyte;
			if (wr_office_hys) office_hys_r <= wbyte;
			if (wr_night_trip) night_trip_r <= wbyte;
			if (wr_night_hys) night_hys_r <= wbyte;
		end
	end

	// Automatic adjust enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_r <= 1'b0;
		end else if (wr_ctrl) begin
			auto_r <= wbyte[CTRL_AUTO_BIT];
		end
	end

	wire [31:0] filter_period = 32'(FILTER_BASE_CYCLES) << settle_sel_r;

	// Office comparator
	// office enable, thresholds
	level_comparator #(
		.CW(32)
	) u_office_comparator (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.enable(office_on_r),
		.force_conv(force_r),
		.light(office_light_code),
		.trip(office_trip_r),
		.hys(office_hys_r),
		.period(filter_period),
		.flag(office_flag),
		.rise(office_rise)
	);

	// Night comparator
	// night enable, thresholds
	level_comparator #(
		.CW(32)
	) u_night_comparator (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.enable(night_on_r),
		.force_conv(force_r),
		.light(night_light_code),
		.trip(night_trip_r),
		.hys(night_hys_r),
		.period(filter_period),
		.flag(night_flag),
		.rise(night_rise)
	);

	// night priority, only with auto adjust
	assign level_nxt = !auto_r ? LVL_DAY
		: night_flag ? LVL_NIGHT
		: office_flag ? LVL_OFFICE
		: LVL_DAY;

	// Code of the chosen level, dim or peak
	always_comb begin
		case (level_nxt)
			LVL_NIGHT: code_nxt = dim_active ? night_dim_r : night_peak_r;
			LVL_OFFICE: code_nxt = dim_active ? office_dim_r : office_peak_r;
			LVL_DAY: code_nxt = dim_active ? day_dim_r : day_peak_r;
			default: code_nxt = day_peak_r;
		endcase
	end

	// Present code and level registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backlight_code_r <= RST_CODE;
			level_r <= LVL_DAY;
		end else if (ce) begin
			backlight_code_r <= code_nxt;
			level_r <= level_nxt;
		end
	end

	// Sticky events; a new event beats a clear
	wire [IRQ_W-1:0] irq_event = {force_r, office_rise, night_rise};
	wire [IRQ_W-1:0] irq_clear = wr_irq_stat ? wbyte[IRQ_W-1:0] : RST_IRQ;
	assign irq_stat_nxt = (irq_stat_r & ~irq_clear) | irq_event;

	// Interrupt status and mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= RST_IRQ;
			irq_mask_r <= RST_IRQ;
		end else if (ce) begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_irq_mask) irq_mask_r <= wbyte[IRQ_W-1:0];
		end
	end

	// Read selection; unused bit 7 of code registers reads zero
	// present code readback, flags
	wire [7:0] cfg_rd = {settle_sel_r, force_r, night_flag, office_flag, night_on_r, office_on_r};
	assign rdata = hit_day_peak ? {1'b0, day_peak_r}
		: hit_day_dim ? {1'b0, day_dim_r}
		: hit_office_peak ? {1'b0, office_peak_r}
		: hit_office_dim ? {1'b0, office_dim_r}
		: hit_night_peak ? {1'b0, night_peak_r}
		: hit_night_dim ? {1'b0, night_dim_r}
		: hit_present ? {1'b0, backlight_code_r}
		: hit_cfg ? cfg_rd
		: hit_office_trip ? office_trip_r
		: hit_office_hys ? office_hys_r
		: hit_night_trip ? night_trip_r
		: hit_night_hys ? night_hys_r
		: hit_ctrl ? {7'h00, auto_r}
		: hit_irq_stat ? {5'h00, irq_stat_r}
		: hit_irq_mask ? {5'h00, irq_mask_r}
		: 8'h00;

	// Read data loaded at setup, or late when setup saw ce low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			rd_loaded_r <= 1'b0;
		end else if (ce) begin
			rd_loaded_r <= load_rd;
			if (load_rd) prdata_r <= {24'h00_0000, rdata};
		end
	end

	// Bus answer and block outputs
	assign prdata = prdata_r;
	assign pready = ce && (!penable || rd_loaded_r);
	assign pslverr = access_phase && !addr_hit;
	assign backlight_code = backlight_code_r;
	assign selected_light_level = level_r;
	assign irq = |(irq_stat_r & irq_mask_r);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Forced read steps
	sequence s_force_write;
		ce && wr_cfg && wbyte[CFG_FORCE_BIT];
	endsequence
	sequence s_force_drain;
		ce && force_r && !wr_cfg;
	endsequence

	a_force_sets: assert property (s_force_write |=> force_r)
		else $error("forced read not started");
	a_force_self_clear: assert property (s_force_write ##1 s_force_drain |=> !force_r)
		else $error("forced read bit not cleared");
	a_office_peak_store: assert property (wr_office_peak |=> office_peak_r == $past(wbyte[6:0]))
		else $error("office peak code not stored");
	a_night_dim_pick: assert property (ce && auto_r && night_flag && dim_active
		|=> backlight_code == $past(night_dim_r))
		else $error("night dim code not applied");
	a_present_readback: assert property (setup_phase && hit_present
		|=> prdata == {25'h000_0000, $past(backlight_code_r)})
		else $error("present code readback wrong");
	a_present_ro: assert property (wr_fire && hit_present |=> $stable(office_peak_r) && $stable(auto_r))
		else $error("write to present code had effect");
	a_night_priority: assert property (ce && auto_r && night_flag |=> selected_light_level == LVL_NIGHT)
		else $error("night level not preferred");
	a_auto_needed: assert property (ce && !auto_r |=> selected_light_level == LVL_DAY)
		else $error("level changed without auto adjust");
	a_day_code_pick: assert property (ce && !auto_r && !dim_active
		|=> backlight_code == $past(day_peak_r))
		else $error("daylight peak code not applied");
	a_office_flag_read: assert property (setup_phase && hit_cfg
		|=> prdata[CFG_OFFICE_FLAG_BIT] == $past(office_flag))
		else $error("office flag readback wrong");
	a_event_sticky: assert property (ce && night_rise |=> irq_stat_r[IRQ_NIGHT_BIT])
		else $error("night event lost");

endmodule // ambient_level_backlight_select

/* File: tb/apb_host_model.sv */
// Purpose: Host model that reaches the selector registers over APB.
// Assumes: One pclk; slave answers through pready.
// Notes: Every wait is bounded; a slave that never answers sets the timeout flag.
`timescale 1ns/1ps
module apb_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end

	// One transfer, request held until pready is sampled high
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic er, output logic to);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 64) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata[7:0];
		er = pslverr;
		to = (n >= 64);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // apb_host_model

/* File: tb/tb_ambient_level_backlight_select.sv */
// Purpose: Self-checking bench of the ambient level backlight selector.
// Assumes: Short filter base so that settle periods last a few cycles.
// Notes: Register rows first, then level, filter, force, clock enable and reset cases.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_ambient_level_backlight_select;
	import light_level_pkg::*;
	localparam int unsigned BASE = 4;
	typedef struct {logic [5:0] idx; logic [7:0] wd; logic [7:0] rx; logic er;} row_t;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, dim_active, irq;
	logic [7:0] paddr, office_light_code, night_light_code, rd;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [6:0] backlight_code;
	level_t selected_light_level;
	logic er, to;
	int n_fail, cmp_count, n;
	int cnt[3];
	row_t rows[12];

	ambient_level_backlight_select #(.FILTER_BASE_CYCLES(BASE)) ambient_level_backlight_select_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .office_light_code(office_light_code),
		.night_light_code(night_light_code), .dim_active(dim_active),
		.backlight_code(backlight_code), .selected_light_level(selected_light_level), .irq(irq));
	apb_host_model apb_host_model_inst (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Clock at 200 MHz
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Counts, verdict and end of run
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Register access helpers
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb_host_model_inst.xfer(1'b1, idx, d, rd, er, to);
		if (to) begin
			n_fail++;
			complete_run();
		end
		#1;
	endtask
	task automatic rdchk(input logic [5:0] idx, input logic [7:0] x, input logic xe);
		apb_host_model_inst.xfer(1'b0, idx, 8'h00, rd, er, to);
		if (to) begin
			n_fail++;
			complete_run();
		end
		`CHK(rd, x)
		`CHK(er, xe)
	endtask

	// Bounded wait for a level, counting cycles
	task automatic wait_lvl(input level_t l, output int c);
		c = 0;
		#1;
		while (selected_light_level !== l && c < 2000) begin
			@(posedge pclk);
			#1;
			c++;
		end
		if (c >= 2000) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic set_light(input logic [7:0] o, input logic [7:0] nl);
		@(posedge pclk);
		office_light_code <= o;
		night_light_code <= nl;
	endtask
	task automatic set_dim(input logic d);
		@(posedge pclk);
		dim_active <= d;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// Main sequence
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		dim_active = 1'b0;
		office_light_code = 8'hC8;
		night_light_code = 8'hC8;
		n_fail = 0;
		cmp_count = 0;
		rows = '{'{IDX_DAY_PEAK, 8'hA5, 8'h25, 1'b0}, '{IDX_DAY_DIM, 8'h93, 8'h13, 1'b0},
			'{IDX_OFFICE_PEAK, 8'hC1, 8'h41, 1'b0}, '{IDX_OFFICE_DIM, 8'hA2, 8'h22, 1'b0},
			'{IDX_NIGHT_PEAK, 8'hE3, 8'h63, 1'b0}, '{IDX_NIGHT_DIM, 8'h84, 8'h04, 1'b0},
			'{IDX_PRESENT, 8'h7F, 8'h25, 1'b0}, '{IDX_OFFICE_TRIP, 8'h40, 8'h40, 1'b0},
			'{IDX_OFFICE_HYS, 8'h10, 8'h10, 1'b0}, '{IDX_NIGHT_TRIP, 8'h20, 8'h20, 1'b0},
			'{IDX_NIGHT_HYS, 8'h08, 8'h08, 1'b0}, '{6'h30, 8'h55, 8'h00, 1'b1}};
		do_reset();
		foreach (rows[i]) rdchk(rows[i].idx, 8'h00, rows[i].er);
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rdchk(rows[i].idx, rows[i].rx, rows[i].er);
		end
		`CHK(backlight_code, 7'h25)
		wr(IDX_IRQ_MASK, 8'h07);
		wr(IDX_CFG, 8'h03);
		// Host also sets automatic adjust
		wr(IDX_CTRL, 8'h01);
		set_dim(1'b1);
		settle(3);
		`CHK(backlight_code, 7'h13)
		set_dim(1'b0);
		set_light(8'h30, 8'hC8);
		settle(2);
		`CHK(selected_light_level, LVL_DAY)
		wait_lvl(LVL_OFFICE, n);
		settle(2);
		`CHK(backlight_code, 7'h41)
		`CHK(irq, 1'b1)
		rdchk(IDX_CFG, 8'h07, 1'b0);
		rdchk(IDX_IRQ_STAT, 8'h02, 1'b0);
		wr(IDX_IRQ_STAT, 8'h02);
		`CHK(irq, 1'b0)
		set_light(8'h50, 8'hC8);
		settle(20);
		`CHK(selected_light_level, LVL_OFFICE)
		set_light(8'h51, 8'hC8);
		wait_lvl(LVL_DAY, n);
		set_light(8'h30, 8'h10);
		wait_lvl(LVL_NIGHT, n);
		set_dim(1'b1);
		settle(3);
		`CHK(backlight_code, 7'h04)
		set_dim(1'b0);
		settle(3);
		`CHK(backlight_code, 7'h63)
		set_light(8'h30, 8'h28);
		settle(20);
		`CHK(selected_light_level, LVL_NIGHT)
		set_light(8'h30, 8'h29);
		wait_lvl(LVL_OFFICE, n);
		set_light(8'h30, 8'h10);
		wait_lvl(LVL_NIGHT, n);
		wr(IDX_CFG, 8'h01);
		wait_lvl(LVL_OFFICE, n);
		wr(IDX_CFG, 8'h00);
		wait_lvl(LVL_DAY, n);
		wr(IDX_IRQ_MASK, 8'h00);
		`CHK(irq, 1'b0)
		wr(IDX_IRQ_MASK, 8'h07);
		`CHK(irq, 1'b1)
		wr(IDX_IRQ_STAT, 8'h07);
		// Settle time per filter code
		for (int f = 0; f < 3; f++) begin
			set_light(8'hC8, 8'hC8);
			wr(IDX_CFG, {f[2:0], 5'h01});
			set_light(8'h30, 8'hC8);
			wait_lvl(LVL_OFFICE, cnt[f]);
			`CHK(cnt[f] - cnt[0], (BASE << f) - BASE)
			set_light(8'hC8, 8'hC8);
			wait_lvl(LVL_DAY, n);
		end
		// Forced conversion beats a long settle period
		wr(IDX_CFG, 8'hE1);
		set_light(8'h30, 8'hC8);
		wr(IDX_CFG, 8'hF1);
		wait_lvl(LVL_OFFICE, n);
		`CHK(n < 10, 1'b1)
		rdchk(IDX_CFG, 8'hE5, 1'b0);
		rdchk(IDX_IRQ_STAT, 8'h06, 1'b0);
		// Clock enable low freezes the settle count and stalls the bus
		set_light(8'hC8, 8'hC8);
		ce <= 1'b0;
		fork
			rdchk(IDX_CFG, 8'hE5, 1'b0);
			begin
				repeat (40) @(posedge pclk);
				`CHK(selected_light_level, LVL_OFFICE)
				ce <= 1'b1;
			end
		join
		// Frozen cycles must not count towards the settle period
		wait_lvl(LVL_DAY, n);
		`CHK(n > 480, 1'b1)
		do_reset();
		foreach (rows[i]) rdchk(rows[i].idx, 8'h00, rows[i].er);
		`CHK(selected_light_level, LVL_DAY)
		complete_run();
	end
endmodule // tb_ambient_level_backlight_select
